// ---- design/lct_pkg.sv ----
// Purpose: shared constants and types for the loop channel output timing block
// Assumes: 200 MHz clock, millisecond tick as the common time base
// Notes:   all times are in their printed unit; cycle counts are derived
package lct_pkg;

    localparam int          NUM_CH        = 2;
    // clock and time base
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          MS_PS         = 1000000000;
    localparam int          CYC_PER_MS    = MS_PS / CLK_PERIOD_PS;
    // presence limits in minutes and in ms
    localparam int          PRES_SHORT_MIN = 30;
    localparam int          PRES_LONG_MIN  = 120;
    localparam logic [22:0] PRES_SHORT_MS  = 23'(PRES_SHORT_MIN * 60 * 1000);
    localparam logic [22:0] PRES_LONG_MS   = 23'(PRES_LONG_MIN * 60 * 1000);
    // pulse, delay and extend units in ms
    localparam logic [7:0]  PULSE_MS      = 8'h7d;
    localparam logic [15:0] DELAY_UNIT_MS = 16'h03e8;
    localparam logic [15:0] EXT_UNIT_MS   = 16'h00fa;
    // status output widths in ms
    localparam logic [7:0]  ST_OPEN_MS    = 8'h32;
    localparam logic [7:0]  ST_SHORT_MS   = 8'h64;
    localparam logic [7:0]  ST_INDUCT_MS  = 8'h96;
    localparam logic [7:0]  ST_LOW_MS     = 8'h32;
    // indicator blink, period 500 ms
    localparam logic [8:0]  BLINK_PERIOD_MS = 9'h1f4;
    localparam logic [8:0]  BLINK_QUART_MS  = 9'h07d;
    // register map and fields
    localparam logic [7:0]  REG_MODE0     = 8'h00;
    localparam logic [7:0]  REG_MODE1     = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_FAULT     = 8'h0c;
    localparam int          ST_CH_STRIDE  = 8;
    localparam int          FLT_CH_STRIDE = 2;

    typedef enum logic [2:0] {
        LCT_MODE_OFF        = 3'h0,
        LCT_MODE_PRES_SHORT = 3'h1,
        LCT_MODE_PRES_LONG  = 3'h2,
        LCT_MODE_PULSE      = 3'h3,
        LCT_MODE_CALL       = 3'h4
    } lct_mode_t;
    localparam lct_mode_t   MODE_RESET    = LCT_MODE_PRES_SHORT;

    typedef enum logic [1:0] {
        LCT_FLT_NONE   = 2'h0,
        LCT_FLT_OPEN   = 2'h1,
        LCT_FLT_SHORT  = 2'h2,
        LCT_FLT_INDUCT = 2'h3
    } lct_fault_t;

    typedef enum logic [1:0] {
        LCT_DISP_NONE   = 2'h0,
        LCT_DISP_DELAY  = 2'h1,
        LCT_DISP_EXTEND = 2'h2,
        LCT_DISP_FAULT  = 2'h3
    } lct_disp_t;

    // detection input from the loop measurement logic
    typedef struct packed {
        logic vehicle;
        logic open_loop;
        logic short_loop;
        logic induct_change;
    } lct_det_t;

    // board switch banks of one channel
    typedef struct packed {
        logic [5:0] delay_sec;
        logic [5:0] extend_qsec;
    } lct_sw_t;

endpackage

// ---- design/lct_channel_timing.sv ----
// Purpose: two-channel loop detector output modes, delay/extend timing, status line
// Assumes: detection inputs are on clk; pins (switches, timer control, strap,
//          fail) are asynchronous and pass two flip-flops first
// Notes:   one ms tick drives every timer
//
// The address map and strobed register access were chosen for this implementation.
module lct_channel_timing #(
    parameter int CYC_PER_MS = lct_pkg::CYC_PER_MS
) (
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    input  wire lct_pkg::lct_det_t [lct_pkg::NUM_CH-1:0] det_in,
    input  wire lct_pkg::lct_sw_t  [lct_pkg::NUM_CH-1:0] sw_pins,
    input  wire logic [lct_pkg::NUM_CH-1:0]              timer_ctrl_n,
    input  wire logic                                    green_extend_option_strap,
    input  wire logic                                    watchdog_fail,
    input  wire logic [7:0]                              addr,
    input  wire logic [31:0]                             wdata,
    input  wire logic                                    wr,
    input  wire logic                                    rd,
    output logic [31:0]                                  rdata,
    output logic [lct_pkg::NUM_CH-1:0]                   call_out,
    output logic [lct_pkg::NUM_CH-1:0]                   detect_indicator,
    output logic [lct_pkg::NUM_CH-1:0]                   fault_indicator,
    output logic [lct_pkg::NUM_CH-1:0]                   status_out,
    output logic [lct_pkg::NUM_CH-1:0]                   osc_enable,
    output lct_pkg::lct_disp_t [lct_pkg::NUM_CH-1:0]     display
);
    import lct_pkg::*;

    typedef enum logic [2:0] {
        LCT_ST_IDLE   = 3'h0,
        LCT_ST_DELAY  = 3'h1,
        LCT_ST_ACTIVE = 3'h3,
        LCT_ST_EXTEND = 3'h2,
        LCT_ST_MAXED  = 3'h6
    } lct_state_t;

    function automatic lct_fault_t fault_code(input lct_det_t d);
        if (d.open_loop) begin
            return LCT_FLT_OPEN;
        end else if (d.short_loop) begin
            return LCT_FLT_SHORT;
        end else if (d.induct_change) begin
            return LCT_FLT_INDUCT;
        end
        return LCT_FLT_NONE;
    endfunction

    function automatic logic is_presence(input lct_mode_t m);
        return (m == LCT_MODE_PRES_SHORT) || (m == LCT_MODE_PRES_LONG);
    endfunction

    // pin synchronisers
    lct_sw_t    [NUM_CH-1:0] sw_s1;
    lct_sw_t    [NUM_CH-1:0] sw;
    logic       [NUM_CH-1:0] tc_s1;
    logic       [NUM_CH-1:0] tc_n;
    logic                    strap_s1;
    logic                    strap;
    logic                    wd_s1;
    logic                    wd;

    always_ff @(posedge clk) begin
        if (rst) begin
            sw_s1    <= '0;
            sw       <= '0;
            tc_s1    <= '1;
            tc_n     <= '1;
            strap_s1 <= 1'b0;
            strap    <= 1'b0;
            wd_s1    <= 1'b0;
            wd       <= 1'b0;
        end else begin
            sw_s1    <= sw_pins;
            sw       <= sw_s1;
            tc_s1    <= timer_ctrl_n;
            tc_n     <= tc_s1;
            strap_s1 <= green_extend_option_strap;
            strap    <= strap_s1;
            wd_s1    <= watchdog_fail;
            wd       <= wd_s1;
        end
    end

    // millisecond tick and blink phase
    logic [31:0] pre_cnt;
    logic        tick;
    logic [8:0]  blink_cnt;
    logic        blink2;
    logic        blink4;

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt <= '0;
            tick    <= 1'b0;
        end else if (pre_cnt == 32'(CYC_PER_MS - 1)) begin
            pre_cnt <= '0;
            tick    <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 32'h1;
            tick    <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            blink_cnt <= '0;
        end else if (tick) begin
            blink_cnt <= (blink_cnt == BLINK_PERIOD_MS - 9'h1) ? 9'h0 : blink_cnt + 9'h1;
        end
    end

    assign blink2 = blink_cnt < 9'(2 * BLINK_QUART_MS);
    assign blink4 = (blink_cnt < BLINK_QUART_MS) ||
                    ((blink_cnt >= 9'(2 * BLINK_QUART_MS)) &&
                     (blink_cnt < 9'(3 * BLINK_QUART_MS)));

    // register file
    lct_mode_t  [NUM_CH-1:0] mode;
    lct_fault_t [NUM_CH-1:0] last_fault;
    logic       [NUM_CH-1:0] mode_wr;
    lct_state_t [NUM_CH-1:0] state;
    logic       [NUM_CH-1:0] veh_q;

    assign mode_wr[0] = wr && (addr == REG_MODE0);
    assign mode_wr[1] = wr && (addr == REG_MODE1);

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= '{default: MODE_RESET};
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (mode_wr[c]) begin
                    mode[c] <= lct_mode_t'(wdata[2:0]);
                end
            end
        end
    end

    // fault type kept, new fault wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            last_fault <= '{default: LCT_FLT_NONE};
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (mode[c] != LCT_MODE_OFF && fault_code(det_in[c]) != LCT_FLT_NONE) begin
                    last_fault[c] <= fault_code(det_in[c]);
                end else if (wr && addr == REG_FAULT && wdata[c]) begin
                    last_fault[c] <= LCT_FLT_NONE;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= '0;
            if (rd) begin
                unique case (addr)
                    REG_MODE0:  rdata <= {29'h0, mode[0]};
                    REG_MODE1:  rdata <= {29'h0, mode[1]};
                    REG_STATUS: begin
                        for (int c = 0; c < NUM_CH; c++) begin
                            rdata[c*ST_CH_STRIDE +: ST_CH_STRIDE] <=
                                {3'h0, strap, veh_q[c], state[c] == LCT_ST_EXTEND,
                                 state[c] == LCT_ST_DELAY, call_out[c]};
                        end
                    end
                    REG_FAULT:  rdata <= {28'h0, last_fault[1], last_fault[0]};
                    default:    rdata <= '0;
                endcase
            end
        end
    end

    // per-channel call state machines
    logic [15:0] tmr      [NUM_CH];
    logic [22:0] pres_cnt [NUM_CH];
    logic [7:0]  pulse_cnt[NUM_CH];
    logic [NUM_CH-1:0] veh;
    logic [NUM_CH-1:0] arrive;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            veh[c]    = det_in[c].vehicle && (mode[c] != LCT_MODE_OFF);
            arrive[c] = veh[c] && !veh_q[c];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            veh_q <= '0;
        end else begin
            veh_q <= veh;
        end
    end

    // each channel has its own state and timers
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= '{default: LCT_ST_IDLE};
            tmr       <= '{default: 16'h0};
            pres_cnt  <= '{default: 23'h0};
            pulse_cnt <= '{default: 8'h0};
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (tick && pulse_cnt[c] != 8'h0) begin
                    pulse_cnt[c] <= pulse_cnt[c] - 8'h1;
                end
                // forced call and off skip timing
                if (mode_wr[c] || mode[c] == LCT_MODE_OFF || mode[c] == LCT_MODE_CALL) begin
                    state[c]     <= LCT_ST_IDLE;
                    pulse_cnt[c] <= 8'h0;
                end else begin
                    unique case (state[c])
                        LCT_ST_IDLE: begin
                            if (arrive[c]) begin
                                if (sw[c].delay_sec != 6'h0 && tc_n[c]) begin
                                    state[c] <= LCT_ST_DELAY;
                                    tmr[c]   <= 16'(sw[c].delay_sec * DELAY_UNIT_MS);
                                end else begin
                                    state[c]    <= LCT_ST_ACTIVE;
                                    pres_cnt[c] <= 23'h0;
                                    if (mode[c] == LCT_MODE_PULSE) begin
                                        pulse_cnt[c] <= PULSE_MS;
                                    end
                                end
                            end
                        end
                        LCT_ST_DELAY: begin
                            if (!veh[c]) begin
                                state[c] <= LCT_ST_IDLE;
                            end else if (!tc_n[c] || (tick && tmr[c] == 16'h1)) begin
                                state[c]    <= LCT_ST_ACTIVE;
                                pres_cnt[c] <= 23'h0;
                                if (mode[c] == LCT_MODE_PULSE) begin
                                    pulse_cnt[c] <= PULSE_MS;
                                end
                            end else if (tick) begin
                                tmr[c] <= tmr[c] - 16'h1;
                            end
                        end
                        LCT_ST_ACTIVE: begin
                            if (!veh[c]) begin
                                if (is_presence(mode[c]) && sw[c].extend_qsec != 6'h0 &&
                                    (!strap || !tc_n[c])) begin
                                    state[c] <= LCT_ST_EXTEND;
                                    tmr[c]   <= 16'(sw[c].extend_qsec * EXT_UNIT_MS);
                                end else begin
                                    state[c] <= LCT_ST_IDLE;
                                end
                            end else if (tick && is_presence(mode[c])) begin
                                if (pres_cnt[c] == ((mode[c] == LCT_MODE_PRES_LONG) ?
                                                    PRES_LONG_MS : PRES_SHORT_MS) - 23'h1) begin
                                    state[c] <= LCT_ST_MAXED;
                                end
                                pres_cnt[c] <= pres_cnt[c] + 23'h1;
                            end
                        end
                        LCT_ST_EXTEND: begin
                            if (veh[c]) begin
                                state[c]    <= LCT_ST_ACTIVE;
                                pres_cnt[c] <= 23'h0;
                            end else if (tick) begin
                                if (tmr[c] == 16'h1) begin
                                    state[c] <= LCT_ST_IDLE;
                                end
                                tmr[c] <= tmr[c] - 16'h1;
                            end
                        end
                        LCT_ST_MAXED: begin
                            if (!veh[c]) begin
                                state[c] <= LCT_ST_IDLE;
                            end
                        end
                        default: state[c] <= LCT_ST_IDLE;
                    endcase
                end
            end
        end
    end

    // call, indicators, display
    always_ff @(posedge clk) begin
        if (rst) begin
            call_out         <= '0;
            detect_indicator <= '0;
            fault_indicator  <= '0;
            osc_enable       <= '0;
            display          <= '{default: LCT_DISP_NONE};
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                unique case (mode[c])
                    LCT_MODE_OFF:   call_out[c] <= 1'b0;
                    LCT_MODE_CALL:  call_out[c] <= 1'b1;
                    LCT_MODE_PULSE: call_out[c] <= pulse_cnt[c] != 8'h0;
                    // call held in extend, withheld in delay
                    default: call_out[c] <= (state[c] == LCT_ST_ACTIVE) ||
                                            (state[c] == LCT_ST_EXTEND);
                endcase
                osc_enable[c] <= mode[c] != LCT_MODE_OFF;
                if (state[c] == LCT_ST_DELAY) begin
                    detect_indicator[c] <= blink2;
                end else if (state[c] == LCT_ST_EXTEND) begin
                    detect_indicator[c] <= blink4;
                end else begin
                    detect_indicator[c] <= veh[c];
                end
                fault_indicator[c] <= (last_fault[c] != LCT_FLT_NONE) && blink2;
                if (mode[c] != LCT_MODE_OFF && fault_code(det_in[c]) != LCT_FLT_NONE) begin
                    display[c] <= LCT_DISP_FAULT;
                end else if (state[c] == LCT_ST_DELAY) begin
                    display[c] <= LCT_DISP_DELAY;
                end else if (state[c] == LCT_ST_EXTEND) begin
                    display[c] <= LCT_DISP_EXTEND;
                end else begin
                    display[c] <= LCT_DISP_NONE;
                end
            end
        end
    end

    // status line, pulsed high on fault, held high on watchdog fail
    logic [7:0] st_cnt[NUM_CH];
    logic [7:0] st_hi [NUM_CH];

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            unique case (fault_code(det_in[c]))
                LCT_FLT_OPEN:   st_hi[c] = ST_OPEN_MS;
                LCT_FLT_SHORT:  st_hi[c] = ST_SHORT_MS;
                LCT_FLT_INDUCT: st_hi[c] = ST_INDUCT_MS;
                default:        st_hi[c] = 8'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_cnt     <= '{default: 8'h0};
            status_out <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (wd) begin
                    st_cnt[c]     <= 8'h0;
                    status_out[c] <= 1'b1;
                end else if (st_hi[c] == 8'h0 || mode[c] == LCT_MODE_OFF) begin
                    st_cnt[c]     <= 8'h0;
                    status_out[c] <= 1'b0;
                end else begin
                    // one extra tick high, never short
                    status_out[c] <= st_cnt[c] <= st_hi[c];
                    if (tick) begin
                        st_cnt[c] <= (st_cnt[c] >= st_hi[c] + ST_LOW_MS) ?
                                     8'h0 : st_cnt[c] + 8'h1;
                    end
                end
            end
        end
    end

endmodule

// ---- dv/lct_chk.sv ----
// Purpose: port-level assertions for the loop channel output timing block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   pulse widths are counted in clock cycles from the ms base
module lct_chk #(
    parameter int CYC_PER_MS = 2
) (
    input wire logic                                    clk,
    input wire logic                                    rst,
    input wire lct_pkg::lct_det_t [lct_pkg::NUM_CH-1:0] det_in,
    input wire logic                                    watchdog_fail,
    input wire logic [7:0]                              addr,
    input wire logic [31:0]                             wdata,
    input wire logic                                    wr,
    input wire logic                                    rd,
    input wire logic [31:0]                             rdata,
    input wire logic [lct_pkg::NUM_CH-1:0]              call_out,
    input wire logic [lct_pkg::NUM_CH-1:0]              status_out,
    input wire logic [lct_pkg::NUM_CH-1:0]              osc_enable,
    input wire lct_pkg::lct_disp_t [lct_pkg::NUM_CH-1:0] display
);
    timeunit 1ns;
    timeprecision 1ps;
    import lct_pkg::*;
    localparam int OPEN_W   = 50 * CYC_PER_MS;
    localparam int OPEN_MAX = 60 * CYC_PER_MS;
    int hi_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // high time of the channel 0 status line
    always_ff @(posedge clk) begin
        if (rst || !status_out[0]) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    a_wdog_status_high: assert property (watchdog_fail [*4] |-> ##1 status_out == 2'b11)
        else $error("status not high on watchdog fail");
    a_status_low_ok: assert property (
        (!watchdog_fail && det_in[0][2:0] == 3'h0) [*8] |-> !status_out[0])
        else $error("status high without fault");
    a_open_width: assert property ($fell(status_out[0]) && det_in[0].open_loop
        && !watchdog_fail |-> hi_cnt >= OPEN_W && hi_cnt <= OPEN_MAX)
        else $error("open loop status width wrong");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside read cycle");
    a_delay_withhold: assert property ((display[0] == LCT_DISP_DELAY) [*2] |-> !call_out[0])
        else $error("call during delay");
    a_extend_holds: assert property (display[0] == LCT_DISP_EXTEND |-> call_out[0])
        else $error("call dropped during extension");
    a_off_no_call: assert property (!osc_enable[1] [*2] |-> !call_out[1])
        else $error("call from channel that is off");
    a_call_mode_on: assert property (wr && addr == REG_MODE0 && wdata[2:0] == 3'h4
        |-> ##[1:3] call_out[0])
        else $error("forced call not asserted");
    a_chan_off_osc: assert property (wr && addr == REG_MODE1 && wdata[2:0] == 3'h0
        |-> ##[1:3] !osc_enable[1])
        else $error("oscillator not stopped");
    c_delay: cover property (display[0] == LCT_DISP_DELAY);
    c_extend: cover property (display[0] == LCT_DISP_EXTEND);
    c_open_pulse: cover property ($fell(status_out[0]) && det_in[0].open_loop);
endmodule

bind lct_channel_timing lct_chk #(.CYC_PER_MS(CYC_PER_MS)) lct_chk_inst (
    .clk(clk), .rst(rst), .det_in(det_in), .watchdog_fail(watchdog_fail),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .call_out(call_out),
    .status_out(status_out), .osc_enable(osc_enable), .display(display));

// ---- dv/lct_ctrl_model.sv ----
// Purpose: controller and status collector standing beyond the channel pins
// Assumes: green request comes from the bench
// Notes:   measures the last high width of channel 1 status
module lct_ctrl_model (
    input  wire logic        clk,
    input  wire logic        green,
    input  wire logic [1:0]  status_out,
    output logic      [1:0]  timer_ctrl_n,
    output logic      [15:0] hi_w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    initial begin
        timer_ctrl_n = 2'b11;
        hi_w = 16'h0;
        cnt = 16'h0;
    end
    always @(posedge clk) timer_ctrl_n <= {2{~green}};
    always @(posedge clk) begin
        cnt <= status_out[1] ? cnt + 16'h1 : 16'h0;
        if (!status_out[1] && cnt != 16'h0) hi_w <= cnt;
    end
endmodule

// ---- dv/tb_lct_channel_timing.sv ----
// Purpose: directed bench for modes, delay, extension and status line
// Assumes: CYC_PER_MS of 2, so one ms is two clocks
// Notes:   checks sample 1 ns after the edge
`define CHK(nm, e, g) begin #1; total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_lct_channel_timing;
    timeunit 1ns;
    timeprecision 1ps;
    import lct_pkg::*;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    lct_det_t [NUM_CH-1:0] det_in = '0;
    lct_sw_t [NUM_CH-1:0]  sw_pins = {12'h0, 6'h01, 6'h05};
    logic [NUM_CH-1:0]     timer_ctrl_n, call_out, det_ind, flt_ind, status_out, osc_enable;
    logic                  strap = 1'b0, wdog = 1'b0, wr = 1'b0, rd = 1'b0, green = 1'b0, lvl;
    logic [7:0]            addr = 8'h0;
    logic [31:0]           wdata = 32'h0, rdata;
    lct_disp_t [NUM_CH-1:0] display;
    logic [15:0]           hi_w;
    int                    miscompares = 0, total_checks = 0, n;
    always #2.5 clk = ~clk;
    lct_channel_timing #(.CYC_PER_MS(2)) lct_channel_timing_inst (
        .clk(clk), .rst(rst), .det_in(det_in), .sw_pins(sw_pins), .timer_ctrl_n(timer_ctrl_n),
        .green_extend_option_strap(strap), .watchdog_fail(wdog), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .call_out(call_out), .detect_indicator(det_ind),
        .fault_indicator(flt_ind), .status_out(status_out), .osc_enable(osc_enable),
        .display(display));
    lct_ctrl_model ctrl_model (.clk(clk), .green(green), .status_out(status_out),
        .timer_ctrl_n(timer_ctrl_n), .hi_w(hi_w));
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        `CHK("rdata", e, rdata)
    endtask
    task automatic wait_call(input int ch, input logic v, input int lim);
        n = 0;
        while (call_out[ch] !== v && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(4);
        rd_chk(REG_MODE0, 32'h1);
        rd_chk(8'h10, 32'h0);
        cyc(1);
        det_in[0].vehicle <= 1'b1;
        cyc(1000);
        #1 lvl = det_ind[0];
        cyc(500);
        `CHK("det_ind", ~lvl, det_ind[0])
        cyc(400);
        `CHK("call", 1'b0, call_out[0])
        `CHK("disp", LCT_DISP_DELAY, display[0])
        wait_call(0, 1'b1, 200);
        `CHK("call", 1'b1, call_out[0])
        cyc(1);
        det_in[0].vehicle <= 1'b0;
        cyc(1000);
        #1 lvl = det_ind[0];
        cyc(250);
        `CHK("det_ind", ~lvl, det_ind[0])
        cyc(1150);
        `CHK("call", 1'b1, call_out[0])
        `CHK("disp", LCT_DISP_EXTEND, display[0])
        cyc(1);
        det_in[0].vehicle <= 1'b1;
        cyc(10);
        det_in[0].vehicle <= 1'b0;
        cyc(2400);
        `CHK("call", 1'b1, call_out[0])
        wait_call(0, 1'b0, 200);
        `CHK("call", 1'b0, call_out[0])
        `CHK("ext_len", 1'b1, (n >= 95 && n <= 110))
        cyc(1);
        det_in[0].vehicle <= 1'b1;
        cyc(500);
        det_in[0].vehicle <= 1'b0;
        cyc(2000);
        `CHK("call", 1'b0, call_out[0])
        cyc(1);
        green <= 1'b1;
        strap <= 1'b1;
        cyc(4);
        det_in[0].vehicle <= 1'b1;
        cyc(10);
        `CHK("call", 1'b1, call_out[0])
        cyc(1);
        det_in[0].vehicle <= 1'b0;
        cyc(100);
        `CHK("call", 1'b1, call_out[0])
        wait_call(0, 1'b0, 2600);
        `CHK("call", 1'b0, call_out[0])
        cyc(1);
        green <= 1'b0;
        cyc(4);
        det_in[0].vehicle <= 1'b1;
        wait_call(0, 1'b1, 2200);
        `CHK("call", 1'b1, call_out[0])
        cyc(1);
        det_in[0].vehicle <= 1'b0;
        cyc(10);
        `CHK("call", 1'b0, call_out[0])
        cyc(1);
        strap <= 1'b0;
        sw_pins[0] <= 12'h0;
        wr_reg(REG_MODE0, 32'h3);
        cyc(4);
        det_in[0].vehicle <= 1'b1;
        wait_call(0, 1'b1, 10);
        wait_call(0, 1'b0, 400);
        `CHK("pulse", 1'b1, (n >= 200 && n <= 300))
        cyc(300);
        `CHK("call", 1'b0, call_out[0])
        cyc(1);
        det_in[0].vehicle <= 1'b0;
        wr_reg(REG_MODE0, 32'h4);
        wr_reg(REG_MODE1, 32'h0);
        det_in[1].vehicle <= 1'b1;
        cyc(5);
        `CHK("call", 1'b1, call_out[0])
        `CHK("osc", 1'b0, osc_enable[1])
        `CHK("call1", 1'b0, call_out[1])
        cyc(1);
        det_in[1].vehicle <= 1'b0;
        det_in[0].open_loop <= 1'b1;
        wr_reg(REG_MODE1, 32'h1);
        cyc(400);
        det_in[0].open_loop <= 1'b0;
        det_in[1].short_loop <= 1'b1;
        cyc(700);
        `CHK("status0", 1'b0, status_out[0])
        `CHK("short_w", 1'b1, (hi_w >= 16'd200 && hi_w <= 16'd220))
        rd_chk(REG_FAULT, 32'h1 | 32'h8);
        lvl = flt_ind[1];
        cyc(500);
        `CHK("flt_ind", ~lvl, flt_ind[1])
        cyc(1);
        det_in[1].short_loop <= 1'b0;
        wdog <= 1'b1;
        cyc(10);
        `CHK("status", 2'b11, status_out)
        cyc(1);
        wdog <= 1'b0;
        cyc(10);
        `CHK("status", 2'b00, status_out)
        wr_reg(REG_FAULT, 32'h3);
        rd_chk(REG_FAULT, 32'h0);
        print_verdict();
    end
endmodule
